// file: rtl/lps_power_save.sv
// Power save sequencer for a graphics LCD controller
// Notes on behaviour
// - Bit 0 of register 08h is the power save enable; writing 1 asks for low power.
// - Low power is entered only after at least one full blank frame reaches the panel.
// - In low power the column drivers get blank data and the row-driver disable goes low.
// - The row-driver disable falls between one and two frames after the request.
// - Register contents are kept through low power and are valid afterwards.
// - Display-memory control outputs hold their levels during low power.
// - Every internal clock is stopped from low power entry until exit, not while the enable waits for the blank frame.
// - Host data bus and wait output float from entry until exit.
// - In low power the panel pins park low, row shift clock high, oscillator stopped.
// - With display off only, the same panel levels apply but oscillator and bus run.
// - Writing 0 to the enable bit leaves low power and normal operation resumes.
// - The indirect power save command has no parameters and acts at once.
// - The indirect system setup command also ends low power.
`timescale 1ns/1ps
module lps_power_save
    import lps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic indirect_mode,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic display_on,
    input wire logic [3:0] pixel_data,
    input wire logic [7:0] host_data_in,
    input wire logic host_wait_in,
    input wire logic host_bus_drive,
    input wire logic [2:0] mem_ctrl_in,
    output logic power_save_en,
    output logic low_power,
    output logic dummy_writes_done,
    output logic clocks_running,
    output logic oscillator_run,
    output logic row_driver_disable,
    output logic frame_pulse,
    output logic line_pulse,
    output logic row_shift_clock,
    output logic column_enable_chain_clock,
    output logic pixel_shift_clock,
    output logic ac_drive_toggle,
    output logic [3:0] panel_data_out,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic host_wait_out,
    output logic host_wait_oe,
    output logic [2:0] mem_ctrl_out
);
    import lps_pkg::*;

    lps_state_t state_r;
    lps_state_t state_nxt;
    logic psave_r;
    logic blank_frame_seen_r;
    logic [1:0] dummy_cnt_r;
    logic row_disable_r;
    logic frame_pulse_r;
    logic line_pulse_r;
    logic row_clk_r;
    logic col_clk_r;
    logic shift_clk_r;
    logic ac_toggle_r;
    logic [3:0] panel_data_r;
    logic [7:0] db_out_r;
    logic db_oe_r;
    logic wait_r;
    logic wait_oe_r;
    logic [2:0] mem_ctrl_r;
    logic low_power_r;
    logic osc_run_r;
    logic dummy_done_r;

    // Host decode
    wire psave_reg_hit = reg_write && !indirect_mode && (reg_addr == PSAVE_REG_IDX);
    wire cmd_psave = cmd_write && indirect_mode && (cmd_code == CMD_POWER_SAVE);
    wire cmd_sysset = cmd_write && indirect_mode && (cmd_code == CMD_SYSTEM_SET);
    wire psave_set = (psave_reg_hit && reg_wdata[PSAVE_BIT]) || cmd_psave;
    wire psave_clr = (psave_reg_hit && !reg_wdata[PSAVE_BIT]) || cmd_sysset;
    wire psave_nxt = psave_set ? 1'b1 : (psave_clr ? 1'b0 : psave_r);
    wire any_write = reg_write || cmd_write;

    // Frame timer runs only while the internal clocks are allowed
    wire in_sleep = (state_r == LPS_SLEEP);
    wire timer_run = clock_enable && !in_sleep;
    wire timer_restart = clock_enable && (state_r == LPS_WAKE);
    wire line_end;
    wire frame_end;
    wire [7:0] col;
    wire [7:0] row;

    lps_frame_timer u_timer (
        .clock(clock),
        .reset(reset),
        .run(timer_run),
        .restart(timer_restart),
        .line_end(line_end),
        .frame_end(frame_end),
        .col(col),
        .row(row)
    );

    // Sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            LPS_RUN:
                if (psave_nxt)
                    state_nxt = LPS_BLANK;
            LPS_BLANK:
                if (!psave_nxt)
                    state_nxt = LPS_RUN;
                else if (frame_end && blank_frame_seen_r)
                    state_nxt = LPS_SLEEP;
            LPS_SLEEP:
                if (!psave_nxt)
                    state_nxt = LPS_WAKE;
            LPS_WAKE:
                state_nxt = LPS_RUN;
        endcase
    end

    // Blanking and parked panel levels
    wire blanking = (state_r != LPS_RUN) || !display_on;
    wire sleeping_nxt = (state_nxt == LPS_SLEEP);
    wire line_pulse_nxt = line_end;
    wire frame_pulse_nxt = frame_end;
    wire shift_nxt = !col[0];
    wire col_clk_nxt = line_end;
    wire row_clk_nxt = !line_end;
    wire [3:0] data_nxt = blanking ? PANEL_DATA_BLANK : pixel_data;
    wire row_disable_nxt = !(state_r == LPS_SLEEP || state_r == LPS_WAKE || !display_on);
    wire [1:0] dummy_need = indirect_mode ? 2'(INDIRECT_DUMMY_WRITES) : 2'(DIRECT_DUMMY_WRITES);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_r <= LPS_RUN;
            psave_r <= 1'b0;
            blank_frame_seen_r <= 1'b0;
            dummy_cnt_r <= 2'h0;
        end
        else if (clock_enable)
        begin
            state_r <= state_nxt;
            psave_r <= psave_nxt;
            if (state_r != LPS_BLANK)
                blank_frame_seen_r <= 1'b0;
            else if (frame_end)
                blank_frame_seen_r <= 1'b1;
            if (state_r == LPS_WAKE)
                dummy_cnt_r <= 2'h0;
            else if (state_r == LPS_RUN && any_write && dummy_cnt_r != dummy_need)
                dummy_cnt_r <= dummy_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            row_disable_r <= 1'b0;
            frame_pulse_r <= 1'b0;
            line_pulse_r <= 1'b0;
            row_clk_r <= 1'b1;
            col_clk_r <= 1'b0;
            shift_clk_r <= 1'b0;
            ac_toggle_r <= 1'b0;
            panel_data_r <= PANEL_DATA_BLANK;
        end
        else if (clock_enable)
        begin
            if (sleeping_nxt || in_sleep || !display_on)
            begin
                frame_pulse_r <= 1'b0;
                line_pulse_r <= 1'b0;
                row_clk_r <= 1'b1;
                col_clk_r <= 1'b0;
                shift_clk_r <= 1'b0;
                ac_toggle_r <= 1'b0;
                panel_data_r <= PANEL_DATA_BLANK;
            end
            else
            begin
                frame_pulse_r <= frame_pulse_nxt;
                line_pulse_r <= line_pulse_nxt;
                row_clk_r <= row_clk_nxt;
                col_clk_r <= col_clk_nxt;
                shift_clk_r <= shift_nxt;
                panel_data_r <= data_nxt;
                if (frame_end)
                    ac_toggle_r <= !ac_toggle_r;
            end
            // Falls at sleep entry, rises the cycle after LPS_WAKE returns to LPS_RUN
            row_disable_r <= row_disable_nxt && !sleeping_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            db_out_r <= 8'h00;
            db_oe_r <= 1'b0;
            wait_r <= 1'b1;
            wait_oe_r <= 1'b1;
            mem_ctrl_r <= 3'h7;
            low_power_r <= 1'b0;
            osc_run_r <= 1'b1;
            dummy_done_r <= 1'b1;
        end
        else if (clock_enable)
        begin
            db_out_r <= host_data_in;
            db_oe_r <= host_bus_drive && !sleeping_nxt;
            wait_r <= host_wait_in;
            wait_oe_r <= !sleeping_nxt;
            if (!sleeping_nxt)
                mem_ctrl_r <= mem_ctrl_in;
            low_power_r <= sleeping_nxt;
            osc_run_r <= !sleeping_nxt;
            dummy_done_r <= (state_r == LPS_RUN) && (dummy_cnt_r == dummy_need);
        end
    end

    assign power_save_en = psave_r;
    assign low_power = low_power_r;
    assign dummy_writes_done = dummy_done_r;
    assign clocks_running = osc_run_r;
    assign oscillator_run = osc_run_r;
    assign row_driver_disable = row_disable_r;
    assign frame_pulse = frame_pulse_r;
    assign line_pulse = line_pulse_r;
    assign row_shift_clock = row_clk_r;
    assign column_enable_chain_clock = col_clk_r;
    assign pixel_shift_clock = shift_clk_r;
    assign ac_drive_toggle = ac_toggle_r;
    assign panel_data_out = panel_data_r;
    assign host_data_bus_out = db_out_r;
    assign host_data_bus_oe = db_oe_r;
    assign host_wait_out = wait_r;
    assign host_wait_oe = wait_oe_r;
    assign mem_ctrl_out = mem_ctrl_r;
endmodule : lps_power_save

// file: rtl/lps_pkg.sv
// Constants and types for the LCD power save sequencer
package lps_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam logic [7:0] PSAVE_REG_IDX = 8'h08;
    localparam int unsigned PSAVE_BIT = 0;
    localparam logic [7:0] CMD_POWER_SAVE = 8'h53;
    localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
    localparam logic [3:0] PANEL_DATA_BLANK = 4'h0;
    localparam int unsigned LINE_CYCLES = 64;
    localparam int unsigned LINES_PER_FRAME = 8;
    localparam int unsigned DIRECT_DUMMY_WRITES = 1;
    localparam int unsigned INDIRECT_DUMMY_WRITES = 2;
    localparam logic [7:0] LINE_LAST = 8'(LINE_CYCLES - 1);
    localparam logic [7:0] ROW_LAST = 8'(LINES_PER_FRAME - 1);
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        LPS_RUN = 2'b00,
        LPS_BLANK = 2'b01,
        LPS_SLEEP = 2'b11,
        LPS_WAKE = 2'b10
    } lps_state_t;
endpackage : lps_pkg

// file: rtl/lps_frame_timer.sv
// Panel frame and line timing generator, frozen when its clock is gated
`timescale 1ns/1ps
module lps_frame_timer
    import lps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    input wire logic restart,
    output logic line_end,
    output logic frame_end,
    output logic [7:0] col,
    output logic [7:0] row
);
    logic [7:0] col_r;
    logic [7:0] row_r;
    wire col_last = (col_r == LINE_LAST);
    wire row_last = (row_r == ROW_LAST);

    always_ff @(posedge clock)
    begin
        if (reset || restart)
        begin
            col_r <= CNT_ZERO;
            row_r <= CNT_ZERO;
        end
        else if (run)
        begin
            col_r <= col_last ? CNT_ZERO : col_r + CNT_ONE;
            if (col_last)
                row_r <= row_last ? CNT_ZERO : row_r + CNT_ONE;
        end
    end

    assign line_end = run && col_last;
    assign frame_end = run && col_last && row_last;
    assign col = col_r;
    assign row = row_r;
endmodule : lps_frame_timer

// file: sim/lps_power_save_asserts.sv
// Checker for the power save sequencer ports
`timescale 1ns/1ps
module lps_power_save_chk
    import lps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic indirect_mode,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic display_on,
    input wire logic power_save_en,
    input wire logic low_power,
    input wire logic clocks_running,
    input wire logic oscillator_run,
    input wire logic row_driver_disable,
    input wire logic frame_pulse,
    input wire logic line_pulse,
    input wire logic row_shift_clock,
    input wire logic column_enable_chain_clock,
    input wire logic pixel_shift_clock,
    input wire logic ac_drive_toggle,
    input wire logic [3:0] panel_data_out,
    input wire logic host_data_bus_oe,
    input wire logic host_wait_oe,
    input wire logic [2:0] mem_ctrl_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic [10:0] wait_r;
    // Cycles spent waiting for entry since the enable was stored
    always_ff @(posedge clock)
        if (reset || !power_save_en)
            wait_r <= 11'h000;
        else if (clock_enable && !low_power)
            wait_r <= wait_r + 11'h001;
    sequence s_direct(bit v);
        clock_enable && !indirect_mode && reg_write && reg_addr == PSAVE_REG_IDX
            && reg_wdata[PSAVE_BIT] == v;
    endsequence
    sequence s_cmd(logic [7:0] c);
        clock_enable && indirect_mode && cmd_write && cmd_code == c;
    endsequence
    sequence s_wake;
        $fell(low_power) ##0 display_on;
    endsequence
    a_enable_bit_set: assert property (s_direct(1'b1) |=> power_save_en)
        else $error("enable bit not stored");
    a_cmd_acts_now: assert property (s_cmd(CMD_POWER_SAVE) |=> power_save_en)
        else $error("power save command not taken");
    a_entry_frame_window: assert property ($rose(low_power)
        |-> wait_r >= 11'h1ff && wait_r <= 11'h402)
        else $error("entry outside frame window");
    a_pins_parked: assert property (low_power |-> !row_driver_disable && !frame_pulse
        && !line_pulse && row_shift_clock && !column_enable_chain_clock && !pixel_shift_clock
        && !ac_drive_toggle && panel_data_out == PANEL_DATA_BLANK)
        else $error("panel pins not parked");
    a_clocks_stopped: assert property (low_power |-> !oscillator_run && !clocks_running
        && power_save_en)
        else $error("clocks run in low power");
    a_bus_floats: assert property (low_power |-> !host_data_bus_oe && !host_wait_oe)
        else $error("host bus driven in low power");
    a_mem_held: assert property (low_power && $past(low_power) |-> $stable(mem_ctrl_out))
        else $error("memory control moved");
    a_clear_exits: assert property (s_direct(1'b0) |=> !power_save_en ##0 !low_power)
        else $error("clear did not exit");
    a_setup_exits: assert property (s_cmd(CMD_SYSTEM_SET) ##0 low_power |=> !low_power)
        else $error("setup command did not exit");
    a_wake_drivers_on: assert property (s_wake |-> ##[1:3] row_driver_disable)
        else $error("row drivers not back after wake");
    a_display_off_park: assert property (!display_on && $past(!display_on) && !low_power
        |-> !row_driver_disable && oscillator_run && panel_data_out == 4'h0)
        else $error("display off levels wrong");
endmodule : lps_power_save_chk
bind lps_power_save lps_power_save_chk chk (.*);

// file: sim/lps_host_model.sv
// Host side model resolving the shared data and wait lines
`timescale 1ns/1ps
module lps_host_model
(
    input wire logic clock,
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic host_wait_out,
    input wire logic host_wait_oe,
    output logic [7:0] bus_level,
    output logic wait_level
);
    logic [7:0] last_r = 8'h5a;
    logic wait_r = 1'b0;
    // Released lines keep the last driven value for one cycle, then toggle every cycle
    always_ff @(posedge clock)
    begin
        last_r <= host_data_bus_oe ? host_data_bus_out : ~last_r;
        wait_r <= host_wait_oe ? host_wait_out : ~wait_r;
    end
    assign bus_level = host_data_bus_oe ? host_data_bus_out : last_r;
    assign wait_level = host_wait_oe ? host_wait_out : wait_r;
endmodule : lps_host_model

// file: sim/test_lps_power_save.sv
// Self-checking bench for the power save sequencer
`timescale 1ns/1ps
module test_lps_power_save;
    import lps_pkg::*;
    localparam int FRAME = LINE_CYCLES * LINES_PER_FRAME;
    logic clock = 0, reset = 1, clock_enable = 1, indirect_mode = 0, reg_write = 0;
    logic cmd_write = 0, display_on = 1, host_wait_in = 0, host_bus_drive = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cmd_code = 8'h00, host_data_in = 8'h00;
    logic [3:0] pixel_data = 4'h0;
    logic [2:0] mem_ctrl_in = 3'h0, m;
    logic [9:0] p;
    wire logic power_save_en, low_power, dummy_writes_done, clocks_running, oscillator_run;
    wire logic row_driver_disable, frame_pulse, line_pulse, row_shift_clock, wait_level;
    wire logic column_enable_chain_clock, pixel_shift_clock, ac_drive_toggle;
    wire logic host_data_bus_oe, host_wait_out, host_wait_oe;
    wire logic [3:0] panel_data_out;
    wire logic [7:0] host_data_bus_out, bus_level;
    wire logic [2:0] mem_ctrl_out;
    wire logic [9:0] park = {row_driver_disable, frame_pulse, line_pulse, row_shift_clock,
        column_enable_chain_clock, ac_drive_toggle, panel_data_out, oscillator_run};
    int n_mismatch = 0, check_count = 0, n;
    lps_power_save uut (.*);
    lps_host_model host (.*);
    always #4 clock = ~clock;
    always @(negedge clock)
    begin
        pixel_data <= 4'($urandom);
        host_data_in <= 8'($urandom);
        host_wait_in <= 1'($urandom);
        host_bus_drive <= 1'($urandom);
        mem_ctrl_in <= 3'($urandom);
    end
    function automatic logic [9:0] park_exp(input logic sleep);
        return {6'b000100, PANEL_DATA_BLANK, ~sleep};
    endfunction : park_exp
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic put(input logic cmd, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = !cmd;
        cmd_write = cmd;
        reg_addr = a;
        reg_wdata = d;
        cmd_code = d;
        @(negedge clock);
        reg_write = 0;
        cmd_write = 0;
    endtask : put
    task automatic wait_low(input logic v);
        n = 0;
        while (low_power !== v && n < 1200)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 1200)
        begin
            n_mismatch++;
            final_report();
        end
    endtask : wait_low
    initial
    begin
        n = $urandom(11);
        repeat (4) @(negedge clock);
        reset = 0;
        check({power_save_en, low_power, host_wait_oe, oscillator_run, mem_ctrl_out}, 7'h1f);
        put(0, 8'($urandom_range(255, 9)), 8'h01);
        put(1, 8'h00, CMD_POWER_SAVE);
        indirect_mode = 1;
        put(0, PSAVE_REG_IDX, 8'h01);
        indirect_mode = 0;
        check(power_save_en, 1'b0);
        $display("refusal test done");
        put(0, PSAVE_REG_IDX, 8'h01);
        check(power_save_en, 1'b1);
        wait_low(1);
        check(n >= FRAME - 1 && n <= 2 * FRAME + 2, 1'b1);
        @(negedge clock);
        m = mem_ctrl_out;
        check(park, park_exp(1));
        check({pixel_shift_clock, clocks_running, host_data_bus_oe, host_wait_oe}, 4'h0);
        repeat (20) @(negedge clock);
        check(mem_ctrl_out, m);
        check(power_save_en, 1'b1);
        put(0, PSAVE_REG_IDX, 8'h00);
        @(negedge clock);
        check({low_power, dummy_writes_done}, 2'b00);
        put(0, 8'h10, 8'($urandom));
        repeat (2) @(negedge clock);
        check({dummy_writes_done, row_driver_disable}, 2'b11);
        $display("direct test done");
        indirect_mode = 1;
        put(1, 8'h00, CMD_POWER_SAVE);
        check(power_save_en, 1'b1);
        wait_low(1);
        put(1, 8'h00, CMD_SYSTEM_SET);
        @(negedge clock);
        check(low_power, 1'b0);
        put(1, 8'h00, 8'h59);
        check(dummy_writes_done, 1'b0);
        put(1, 8'h00, 8'h59);
        @(negedge clock);
        check(dummy_writes_done, 1'b1);
        $display("indirect test done");
        indirect_mode = 0;
        display_on = 0;
        repeat (4) @(negedge clock);
        check({park, host_wait_oe}, {park_exp(0), 1'b1});
        display_on = 1;
        put(0, PSAVE_REG_IDX, 8'h01);
        repeat (100) @(negedge clock);
        put(0, PSAVE_REG_IDX, 8'h00);
        repeat (2 * FRAME + 8) @(negedge clock);
        check({low_power, power_save_en}, 2'b00);
        $display("display off and cancel test done");
        // Enable low freezes state and refuses a request
        @(negedge clock);
        clock_enable = 0;
        p = park;
        put(0, PSAVE_REG_IDX, 8'h01);
        repeat (3) @(negedge clock);
        check({park, power_save_en}, {p, 1'b0});
        clock_enable = 1;
        $display("clock enable test done");
        final_report();
    end
endmodule : test_lps_power_save
